// ===== verilog/nvram_defines.svh
`ifndef NVRAM_DEFINES_SVH
`define NVRAM_DEFINES_SVH
// Device-type code expected in slave address bits 7-4 (value is arbitrary).
`define DEV_TYPE_CODE  4'h5
`define DEV_TYPE_MSB   7
`define DEV_TYPE_LSB   4
`define PAGE_MSB       3
`define PAGE_LSB       1
`define RW_BIT         0
`define BITS_PER_BYTE  4'h8
`define MEM_DEPTH      2048
`define ADDR_RESET     11'h000
// Master divider reload: one tick per SCL_HALF+1 clk cycles, two ticks per half period of the generated serial clock.
`define SCL_HALF       8'h20
`endif

// ===== verilog/nvram_pkg.sv
package nvram_pkg;
  typedef logic [10:0] addr_t;
  typedef logic [7:0]  byte_t;
  typedef enum logic [1:0] {CMD_WRITE, CMD_READ, CMD_SETADDR} mcmd_e;
endpackage

// ===== verilog/twi_if.sv
`timescale 1ns/1ps
interface twi_if;
  logic scl;       // Serial clock, driven by the master only.
  logic sda_m_oe;  // Master pulls data line low.
  logic sda_s_oe;  // Slave pulls data line low.
  logic sda;       // Resolved open-drain level.
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport slave  (input scl, input sda, output sda_s_oe);
  modport master (output scl, input sda, output sda_m_oe);
endinterface

// ===== verilog/bit_sync.sv
`timescale 1ns/1ps
module bit_sync (
  input  wire logic clk,   // System clock.
  input  wire logic rstn,  // Synchronous reset, active low.
  input  wire logic d,     // Asynchronous input.
  output logic      q      // Synchronised level.
);
  logic meta_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_r <= 1'b1;
      q      <= 1'b1;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // bit_sync

// ===== verilog/nvram_slave.sv
`timescale 1ns/1ps
`include "nvram_defines.svh"
// Behaviour
// - Receiver pulls data low in ninth clock.
// - No acknowledge aborts, device awaits new address.
// - Master withholds acknowledge on last read byte.
// - First byte: device type and page select.
// - Address bit zero picks write or read.
// - Write: second byte sets low address bits.
// - Read uses page select plus latched low bits.
// - Address increments per byte, wraps at top.
// - Read continues only while master acknowledges.
// - Write bytes acknowledged; all bytes MSB first.
// - No busy period after a write.
// - Array written after eighth bit only.
// - Write-protect refuses data, holds address.
// - Current read starts at page plus latch.
// - Master ends read with NACK then Stop.
// - Repeated Start after word address keeps address.
// - Start and Stop are data edges, clock high.
// - Start aborts and rearms address decode.
// - Sample on rising, drive on falling clock.
// - Stop ends any operation.
module nvram_slave
  import nvram_pkg::*;
(
  input  wire logic clk,      // System clock, 100 MHz.
  input  wire logic rstn,     // Synchronous reset, active low.
  input  wire logic wp,       // Write protect, high blocks writes.
  twi_if.slave      bus       // Two-wire link.
);
  typedef enum logic [2:0] {S_IDLE, S_DEVADDR, S_WORDADDR, S_WRDATA, S_RDDATA} st_e;

  // ==========================================================================
  // Pin sampling
  // ==========================================================================
  logic scl_s, sda_s, wp_s, scl_d, sda_d;
  bit_sync u_scl (.clk(clk), .rstn(rstn), .d(bus.scl), .q(scl_s));
  bit_sync u_sda (.clk(clk), .rstn(rstn), .d(bus.sda), .q(sda_s));
  bit_sync u_wp  (.clk(clk), .rstn(rstn), .d(wp),      .q(wp_s));

  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

  // ==========================================================================
  // Protocol engine
  // ==========================================================================
  byte_t      mem [0:`MEM_DEPTH-1];
  st_e        st_r;
  logic [3:0] bit_r;       // 0..7 data bits, 8 = acknowledge slot.
  byte_t      sh_r;
  addr_t      addr_r;
  logic       rd_r;
  logic       oe_r;
  logic       ackok_r;     // This byte will be acknowledged by us.
  byte_t      tx_r;
  byte_t      rx_byte;     // Received byte including the bit sampled now.
  logic       bit_edge;    // A data bit is sampled on this edge.
  logic       byte_end;    // The eighth bit of a byte is sampled on this edge.
  logic       ack_edge;    // The acknowledge bit is sampled on this edge.
  logic       type_ok;     // Device-type field of the received byte matches.

  // Start and Stop need the clock high on two samples, a rising edge needs it
  // low on the earlier one, so the three events never fall in one cycle.
  assign rx_byte  = {sh_r[6:0], sda_s};
  assign bit_edge = scl_rise && (st_r != S_IDLE) && (bit_r < `BITS_PER_BYTE);
  assign byte_end = bit_edge && (bit_r == 4'h7);
  assign ack_edge = scl_rise && (st_r != S_IDLE) && (bit_r == `BITS_PER_BYTE);
  assign type_ok  = (rx_byte[`DEV_TYPE_MSB:`DEV_TYPE_LSB] == `DEV_TYPE_CODE);

  // Frame state: any Start rearms address decode, even in mid-byte.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= S_IDLE;
    end else if (start_c) begin
      st_r <= S_DEVADDR;
    end else if (stop_c) begin
      st_r <= S_IDLE;
    end else if (ack_edge) begin
      case (st_r)
        S_DEVADDR: begin
          if (!ackok_r) begin
            st_r <= S_IDLE;
          end else if (rd_r) begin
            st_r <= S_RDDATA;
          end else begin
            st_r <= S_WORDADDR;
          end
        end
        S_WORDADDR: st_r <= S_WRDATA;
        S_WRDATA:   st_r <= ackok_r ? S_WRDATA : S_IDLE;
        S_RDDATA:   st_r <= sda_s ? S_IDLE : S_RDDATA;
        default:    st_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bit_r <= 4'h0;
    end else if (start_c || ack_edge) begin
      bit_r <= 4'h0;
    end else if (bit_edge) begin
      bit_r <= bit_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sh_r <= 8'h00;
    end else if (bit_edge) begin
      sh_r <= rx_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_r    <= 1'b0;
      ackok_r <= 1'b0;
    end else if (byte_end) begin
      case (st_r)
        S_DEVADDR: begin
          ackok_r <= type_ok;
          rd_r    <= rx_byte[`RW_BIT];
        end
        S_WORDADDR: ackok_r <= 1'b1;
        S_WRDATA:   ackok_r <= ~wp_s;
        default:    ackok_r <= 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Address latch and array
  // ==========================================================================
  // The address advances after every data byte not refused by write protect, just before its acknowledge,
  // and rolls over from the top of the array to zero by plain 11-bit overflow.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      addr_r <= `ADDR_RESET;
    end else if (byte_end) begin
      case (st_r)
        S_DEVADDR: begin
          if (type_ok) begin
            addr_r[10:8] <= rx_byte[`PAGE_MSB:`PAGE_LSB];
          end
        end
        S_WORDADDR: addr_r[7:0] <= rx_byte;
        S_WRDATA: begin
          if (!wp_s) begin
            addr_r <= addr_r + 11'h001;
          end
        end
        S_RDDATA:   addr_r <= addr_r + 11'h001;
        default: ;
      endcase
    end
  end

  // Array write happens only after a complete eighth bit, so an abort earlier
  // in the byte leaves memory untouched.
  always_ff @(posedge clk) begin
    if (rstn && byte_end && st_r == S_WRDATA && !wp_s) begin
      mem[addr_r] <= rx_byte;
    end
  end

  // ==========================================================================
  // Data line drive
  // ==========================================================================
  // The byte is fetched as its first bit is driven, so the address bump after
  // the eighth bit never disturbs the byte already on the wire.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      oe_r <= 1'b0;
      tx_r <= 8'h00;
    end else if (start_c || stop_c) begin
      oe_r <= 1'b0;
    end else if (scl_fall) begin
      oe_r <= 1'b0;
      if (bit_r == `BITS_PER_BYTE && ackok_r &&
          (st_r == S_DEVADDR || st_r == S_WORDADDR || st_r == S_WRDATA)) begin
        oe_r <= 1'b1;
      end else if (st_r == S_RDDATA && bit_r < `BITS_PER_BYTE) begin
        if (bit_r == 4'h0) begin
          tx_r <= mem[addr_r] << 1;
          oe_r <= ~mem[addr_r][7];
        end else begin
          tx_r <= tx_r << 1;
          oe_r <= ~tx_r[7];
        end
      end
    end
  end

  assign bus.sda_s_oe = oe_r;
endmodule // nvram_slave

// ===== verilog/nvram_master.sv
`timescale 1ns/1ps
`include "nvram_defines.svh"
module nvram_master
  import nvram_pkg::*;
(
  input  wire logic clk,      // System clock.
  input  wire logic rstn,     // Synchronous reset, active low.
  input  wire logic req,      // Start one byte operation, pulse.
  input  mcmd_e     cmd,      // Operation kind.
  input  addr_t     addr,     // Byte address.
  input  byte_t     wdata,    // Byte to write.
  output logic      busy,     // Operation in progress.
  output logic      done,     // One-cycle completion pulse.
  output logic      acked,    // All bytes sent by this end acknowledged.
  output byte_t     rdata,    // Byte read.
  twi_if.master     bus       // Two-wire link.
);
  // ==========================================================================
  // Bit-level sequencer
  // ==========================================================================
  // Each operation is one list of up to 5 phases: start, up to 3 bytes, stop.
  // The clock is made here by a divider, so this end needs no resync of it.
  logic sda_s;
  bit_sync u_sda (.clk(clk), .rstn(rstn), .d(bus.sda), .q(sda_s));

  logic [7:0] div_r;
  logic [1:0] q_r;        // Quarter within a bit: 0 low,1 low,2 high,3 high.
  logic [3:0] bit_r;      // 0..8 within byte.
  logic [1:0] byte_r;
  logic [1:0] nbytes_r;
  logic       act_r, start_ph_r, stop_ph_r, rdbyte_r;
  logic       scl_r, oe_r;
  byte_t      sh_r;
  logic [7:0] bytes_r [0:2];
  logic       tick;
  assign tick = (div_r == 8'h00);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      div_r      <= 8'h00;
      act_r      <= 1'b0;
      start_ph_r <= 1'b0;
      stop_ph_r  <= 1'b0;
      rdbyte_r   <= 1'b0;
      scl_r      <= 1'b1;
      oe_r       <= 1'b0;
      q_r        <= 2'h0;
      bit_r      <= 4'h0;
      byte_r     <= 2'h0;
      nbytes_r   <= 2'h0;
      sh_r       <= 8'h00;
      done       <= 1'b0;
      acked      <= 1'b0;
      rdata      <= 8'h00;
      bytes_r[0] <= 8'h00;
      bytes_r[1] <= 8'h00;
      bytes_r[2] <= 8'h00;
    end else begin
      done  <= 1'b0;
      div_r <= tick ? `SCL_HALF : div_r - 8'h01;
      if (!act_r && req) begin
        act_r      <= 1'b1;
        start_ph_r <= 1'b1;
        acked      <= 1'b1;
        q_r        <= 2'h0;
        bit_r      <= 4'h0;
        byte_r     <= 2'h0;
        rdbyte_r   <= (cmd == CMD_READ);
        bytes_r[0] <= {`DEV_TYPE_CODE, addr[10:8], cmd == CMD_READ};
        bytes_r[1] <= (cmd == CMD_READ) ? 8'hff : addr[7:0];
        bytes_r[2] <= wdata;
        nbytes_r   <= (cmd == CMD_READ) ? 2'h2 : (cmd == CMD_SETADDR) ? 2'h2 : 2'h3;
      end else if (act_r && tick) begin
        if (start_ph_r) begin
          // SDA falls with SCL high, then SCL drops.
          if (!oe_r && scl_r) begin
            oe_r <= 1'b1;
          end else begin
            scl_r      <= 1'b0;
            start_ph_r <= 1'b0;
            sh_r       <= bytes_r[0];
          end
        end else if (stop_ph_r) begin
          // SCL rises with SDA held low, then SDA is let go.
          if (scl_r == 1'b0) begin
            oe_r  <= 1'b1;
            scl_r <= 1'b1;
          end else begin
            oe_r      <= 1'b0;
            stop_ph_r <= 1'b0;
            act_r     <= 1'b0;
            done      <= 1'b1;
          end
        end else begin
          q_r <= q_r + 2'h1;
          case (q_r)
            2'h0: begin
              if (bit_r < `BITS_PER_BYTE) begin
                oe_r <= (rdbyte_r && byte_r != 2'h0) ? 1'b0 : ~sh_r[7];
              end else begin
                // Only one byte is ever read, so a read byte is never acknowledged.
                oe_r <= 1'b0;
              end
            end
            2'h1: scl_r <= 1'b1;
            2'h2: begin
              if (bit_r < `BITS_PER_BYTE) begin
                sh_r <= {sh_r[6:0], sda_s};
              end else if (!(rdbyte_r && byte_r != 2'h0) && sda_s) begin
                acked <= 1'b0;
              end
            end
            default: begin
              scl_r <= 1'b0;
              if (bit_r == `BITS_PER_BYTE) begin
                bit_r <= 4'h0;
                if (rdbyte_r && byte_r != 2'h0) begin
                  rdata <= sh_r;
                end
                if (byte_r + 2'h1 == nbytes_r) begin
                  stop_ph_r <= 1'b1;
                  oe_r      <= 1'b1;
                end else begin
                  byte_r <= byte_r + 2'h1;
                  sh_r   <= bytes_r[byte_r + 2'h1];
                end
              end else begin
                bit_r <= bit_r + 4'h1;
              end
            end
          endcase
        end
      end
    end
  end

  assign busy = act_r;
  assign bus.scl = scl_r;
  assign bus.sda_m_oe = oe_r;
endmodule // nvram_master

// ===== test/nvram_link_chk.sv
`timescale 1ns/1ps
`include "nvram_defines.svh"
module nvram_link_chk (
  input wire logic clk,       // System clock.
  input wire logic rstn,      // Synchronous reset, active low.
  input wire logic scl,       // Serial clock.
  input wire logic sda,       // Resolved data line.
  input wire logic sda_m_oe,  // Master pull-down.
  input wire logic sda_s_oe   // Slave pull-down.
);
  logic       scl_r;
  logic       sda_r;
  logic       rw_r;
  logic [3:0] bcnt_r;
  logic [1:0] bidx_r;
  logic [7:0] sh_r;
  wire rise    = scl & ~scl_r;
  wire start   = scl & scl_r & sda_r & ~sda;
  wire ack_clk = rise & (bcnt_r == 4'h8);
  always_ff @(posedge clk) begin
    scl_r <= scl;
    sda_r <= sda;
  end
  // Bit and byte position within a frame, restarted by every Start.
  always_ff @(posedge clk) begin
    if (!rstn || start) begin
      bcnt_r <= 4'h0;
      bidx_r <= 2'h0;
    end else if (ack_clk) begin
      bcnt_r <= 4'h0;
      bidx_r <= bidx_r + {1'b0, bidx_r != 2'h3};
    end else if (rise) begin
      bcnt_r <= bcnt_r + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (rise && !ack_clk) sh_r <= {sh_r[6:0], sda};
    if (ack_clk && bidx_r == 2'h0) rw_r <= sh_r[0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_SLAVE_EDGE: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave changed data while clock high");
  AST_START_BY_MASTER: assert property ($fell(sda) && scl |-> sda_m_oe)
    else $error("start not made by master");
  AST_STOP_BY_MASTER: assert property ($rose(sda) && scl |-> $past(sda_m_oe))
    else $error("stop not made by master");
  AST_NO_CONTENTION: assert property (scl |-> !(sda_m_oe && sda_s_oe))
    else $error("both ends drive data");
  AST_ADDR_ACK: assert property (ack_clk && bidx_r == 2'h0 |->
    sda == (sh_r[7:4] != `DEV_TYPE_CODE))
    else $error("slave address acknowledge wrong");
  AST_WORD_ACK: assert property (ack_clk && bidx_r == 2'h1 && !rw_r |-> !sda)
    else $error("word address not acknowledged");
  AST_READ_NACK: assert property (ack_clk && bidx_r == 2'h1 && rw_r |-> sda)
    else $error("last read byte acknowledged");
  AST_RELEASE_AFTER_NACK: assert property (ack_clk && bidx_r != 2'h0 && sda |=>
    (!sda_s_oe) [*8])
    else $error("slave drives after no-acknowledge");
  cover property (ack_clk && bidx_r == 2'h2 && !rw_r && !sda);
  cover property (ack_clk && bidx_r == 2'h1 && rw_r);
  cover property (start);
endmodule // nvram_link_chk

// ===== test/serial_nvram_slave_access_tb_top.sv
`timescale 1ns/1ps
module serial_nvram_slave_access_tb_top;
  import nvram_pkg::*;
  logic  clk = 1'b0;
  logic  rstn = 1'b0;
  logic  wp = 1'b0;
  logic  req = 1'b0;
  mcmd_e cmd = CMD_WRITE;
  addr_t addr = 11'h000;
  byte_t wdata = 8'h00;
  logic  busy;
  logic  done;
  logic  acked;
  byte_t rdata;
  int    fails = 0;
  int    check_count = 0;
  twi_if bus_if ();
  nvram_master i_nvram_master (.clk(clk), .rstn(rstn), .req(req), .cmd(cmd), .addr(addr),
    .wdata(wdata), .busy(busy), .done(done), .acked(acked), .rdata(rdata),
    .bus(bus_if.master));
  nvram_slave i_nvram_slave (.clk(clk), .rstn(rstn), .wp(wp), .bus(bus_if.slave));
  nvram_link_chk i_nvram_link_chk (.clk(clk), .rstn(rstn), .scl(bus_if.scl),
    .sda(bus_if.sda), .sda_m_oe(bus_if.sda_m_oe), .sda_s_oe(bus_if.sda_s_oe));
  always #5 clk = ~clk;
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  // One whole frame; the frame lasts a few thousand cycles, so the bound is generous.
  task automatic op(input mcmd_e c, input addr_t a, input byte_t d);
    int n;
    @(posedge clk);
    req <= 1'b1;
    cmd <= c;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    chk(8'h01, {7'h00, busy});
    for (n = 0; n < 8000; n++) begin
      @(negedge clk);
      if (done === 1'b1) break;
    end
    if (n == 8000) chk(8'h01, 8'h00);
    chk(8'h00, {7'h00, busy});
  endtask
  task automatic t_write_read();
    op(CMD_WRITE, 11'h3a5, 8'h5c);
    chk(8'h01, {7'h00, acked});
    op(CMD_WRITE, 11'h3a6, 8'hc3);
    op(CMD_SETADDR, 11'h3a5, 8'h00);
    chk(8'h01, {7'h00, acked});
    op(CMD_READ, 11'h3a5, 8'h00);
    chk(8'h5c, rdata);
    // No new word address: a read after a read takes the next location.
    op(CMD_READ, 11'h3a6, 8'h00);
    chk(8'hc3, rdata);
    op(CMD_SETADDR, 11'h3a6, 8'h00);
    op(CMD_READ, 11'h3a6, 8'h00);
    chk(8'hc3, rdata);
    $display("test write_read done");
  endtask
  task automatic t_wrap();
    op(CMD_WRITE, 11'h000, 8'h11);
    op(CMD_WRITE, 11'h7ff, 8'h96);
    // The read follows the write at once and must start at the wrapped address.
    op(CMD_READ, 11'h000, 8'h00);
    chk(8'h11, rdata);
    op(CMD_SETADDR, 11'h7ff, 8'h00);
    op(CMD_READ, 11'h7ff, 8'h00);
    chk(8'h96, rdata);
    // Reading the top byte rolls the latch over to zero.
    op(CMD_READ, 11'h000, 8'h00);
    chk(8'h11, rdata);
    $display("test wrap done");
  endtask
  task automatic t_protect();
    @(posedge clk);
    wp <= 1'b1;
    op(CMD_WRITE, 11'h3a5, 8'hff);
    chk(8'h00, {7'h00, acked});
    @(posedge clk);
    wp <= 1'b0;
    // The refused byte must leave the latch where the word address put it.
    op(CMD_READ, 11'h3a5, 8'h00);
    chk(8'h5c, rdata);
    op(CMD_SETADDR, 11'h3a5, 8'h00);
    op(CMD_READ, 11'h3a5, 8'h00);
    chk(8'h5c, rdata);
    op(CMD_WRITE, 11'h3a5, 8'h3e);
    chk(8'h01, {7'h00, acked});
    $display("test protect done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_write_read();
    t_wrap();
    t_protect();
    end_of_test();
  end
  // Eighteen frames of at most about four thousand cycles each fit inside this span.
  initial begin
    #900000;
    fails++;
    end_of_test();
  end
endmodule // serial_nvram_slave_access_tb_top
